/* core/ssac_step_ctrl.sv */
// serial run-command receiver that steps the electrical angle and drives phase codes
// assumes pins are asynchronous to CLOCK and the serial clock is far slower than CLOCK
`timescale 1ns/1ps
`default_nettype none

module ssac_step_ctrl
    import ssac_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // four-wire serial interface
    input wire logic SCK,
    input wire logic SDI,
    input wire logic STROBE_ACTIVE_LOW,
    output logic SDO,
    output logic SDO_OE,
    // motion state
    output logic [ANGLE_W-1:0] STEP_ANGLE,
    output logic STEP_PULSE,
    // phase current codes
    output logic [DAC_W-1:0] PHASE_A_DAC,
    output logic PHASE_A_NEG,
    output logic [DAC_W-1:0] PHASE_B_DAC,
    output logic PHASE_B_NEG
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection

    logic [SYNC_W-1:0] pins_s;
    logic sck_s;
    logic sdi_s;
    logic strobe_n_s;
    logic sck_d_r;
    logic strobe_n_d_r;
    logic sck_rise;
    logic sck_fall;
    logic strobe_rise;
    logic strobe_fall;

    ssac_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk(CLOCK),
        .srst(SRST),
        .din({SCK, SDI, STROBE_ACTIVE_LOW}),
        .dout(pins_s)
    );

    assign sck_s = pins_s[2];
    assign sdi_s = pins_s[1];
    assign strobe_n_s = pins_s[0];

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            // matches the synchroniser's reset level, so no false edge follows reset
            sck_d_r <= 1'b1;
            strobe_n_d_r <= 1'b1;
        end else begin
            sck_d_r <= sck_s;
            strobe_n_d_r <= strobe_n_s;
        end
    end

    assign sck_rise = sck_s & ~sck_d_r;
    assign sck_fall = ~sck_s & sck_d_r;
    assign strobe_rise = strobe_n_s & ~strobe_n_d_r;
    assign strobe_fall = ~strobe_n_s & strobe_n_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // serial framing

    ssac_ser_e state_r;
    ssac_ser_e state_nxt;
    logic [WORD_BITS-1:0] shift_r;
    logic [WORD_BITS-1:0] shift_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [WORD_BITS-1:0] sdo_sh_r;
    logic [WORD_BITS-1:0] sdo_sh_nxt;
    logic commit;
    logic commit_run;
    logic tbl_we;
    logic [1:0] addr;
    logic [ANGLE_W-1:0] change;
    logic [POS_W-1:0] tbl_idx_r;
    logic [POS_W-1:0] tbl_idx_nxt;
    logic [ANGLE_W-1:0] angle_r;

    // short or long frames are dropped: a half-shifted word must never step the motor
    assign commit = (state_r == SSAC_SHIFT) && strobe_rise && (cnt_r == WORD_CNT);
    assign addr = shift_r[ADDR_HI:ADDR_LO];
    assign change = shift_r[CHANGE_HI:CHANGE_LO];
    assign commit_run = commit && (addr == REG_RUN);
    assign tbl_we = commit && (addr == REG_TBL);

    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        sdo_sh_nxt = sdo_sh_r;
        unique case (state_r)
            SSAC_IDLE: begin
                if (strobe_fall) begin
                    state_nxt = SSAC_SHIFT;
                    cnt_nxt = '0;
                    sdo_sh_nxt = {angle_r, tbl_idx_r, {(WORD_BITS-ANGLE_W-POS_W){1'b0}}};
                end
            end
            SSAC_SHIFT: begin
                if (strobe_rise) begin
                    state_nxt = SSAC_IDLE;
                end else begin
                    // serial clock only moves bits; it never times a step
                    if (sck_rise) begin
                        shift_nxt = {shift_r[WORD_BITS-2:0], sdi_s};
                        if (cnt_r != ~'0) begin
                            cnt_nxt = cnt_r + 5'h01;
                        end
                    end
                    if (sck_fall) begin
                        sdo_sh_nxt = {sdo_sh_r[WORD_BITS-2:0], 1'b0};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state_r <= SSAC_IDLE;
            shift_r <= '0;
            cnt_r <= '0;
            sdo_sh_r <= '0;
        end else begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            sdo_sh_r <= sdo_sh_nxt;
        end
    end

    assign SDO = sdo_sh_r[WORD_BITS-1];
    assign SDO_OE = (state_r == SSAC_SHIFT);

    ////////////////////////////////////////////////////////////////////////////
    // step angle and table load pointer

    logic [ANGLE_W-1:0] angle_nxt;
    logic step_pulse_r;
    logic step_pulse_nxt;

    always_comb begin
        angle_nxt = angle_r;
        step_pulse_nxt = 1'b0;
        tbl_idx_nxt = tbl_idx_r;
        if (commit_run) begin
            // 6-bit sum wraps by itself; a negative change walks backwards
            angle_nxt = angle_r + change;
            step_pulse_nxt = 1'b1;
        end
        if (tbl_we) begin
            tbl_idx_nxt = tbl_idx_r + 4'h1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            angle_r <= ANGLE_RST;
            step_pulse_r <= 1'b0;
            tbl_idx_r <= TBL_FIRST;
        end else begin
            angle_r <= angle_nxt;
            step_pulse_r <= step_pulse_nxt;
            tbl_idx_r <= tbl_idx_nxt;
        end
    end

    assign STEP_ANGLE = angle_r;
    assign STEP_PULSE = step_pulse_r;

    ////////////////////////////////////////////////////////////////////////////
    // quadrant folding and phase codes

    logic [POS_W-1:0] pos;
    logic [1:0] quad;
    logic [IDX_W-1:0] mirror;
    logic [IDX_W-1:0] idx_a;
    logic [IDX_W-1:0] idx_b;
    logic [DAC_W-1:0] mag_a;
    logic [DAC_W-1:0] mag_b;
    logic [DAC_W-1:0] dac_a_r;
    logic [DAC_W-1:0] dac_a_nxt;
    logic [DAC_W-1:0] dac_b_r;
    logic [DAC_W-1:0] dac_b_nxt;
    logic dac_a_neg_r;
    logic dac_a_neg_nxt;
    logic dac_b_neg_r;
    logic dac_b_neg_nxt;

    assign pos = angle_r[POS_W-1:0];
    assign quad = angle_r[ANGLE_W-1:POS_W];
    assign mirror = QUAD_SPAN - {1'b0, pos};
    // phase a follows sine, phase b cosine; phase a reads the table mirrored in odd quadrants, phase b in even ones
    assign idx_a = quad[0] ? mirror : {1'b0, pos};
    assign idx_b = quad[0] ? {1'b0, pos} : mirror;

    ssac_phase_table u_table (
        .clk(CLOCK),
        .srst(SRST),
        .we(tbl_we),
        .widx(tbl_idx_r),
        .wdata(change),
        .idx_a(idx_a),
        .idx_b(idx_b),
        .mag_a(mag_a),
        .mag_b(mag_b)
    );

    always_comb begin
        dac_a_nxt = mag_a;
        dac_b_nxt = mag_b;
        dac_a_neg_nxt = quad[1];
        dac_b_neg_nxt = quad[1] ^ quad[0];
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            dac_a_r <= DAC_ZERO;
            dac_b_r <= DAC_ZERO;
            dac_a_neg_r <= 1'b0;
            dac_b_neg_r <= 1'b0;
        end else begin
            dac_a_r <= dac_a_nxt;
            dac_b_r <= dac_b_nxt;
            dac_a_neg_r <= dac_a_neg_nxt;
            dac_b_neg_r <= dac_b_neg_nxt;
        end
    end

    assign PHASE_A_DAC = dac_a_r;
    assign PHASE_B_DAC = dac_b_r;
    assign PHASE_A_NEG = dac_a_neg_r;
    assign PHASE_B_NEG = dac_b_neg_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic tbl_dirty_r;
    logic [DAC_W-1:0] tbl_wdata;

    assign tbl_wdata = change;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            tbl_dirty_r <= 1'b0;
        end else if (tbl_we) begin
            tbl_dirty_r <= 1'b1;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    a_angle_hold: assert property (
        !commit_run |=> $stable(angle_r)
    ) else $error("angle moved without a run strobe edge");

    a_wrap_up: assert property (
        commit_run && angle_r == ANGLE_MAX && change == 6'h02 |=> angle_r == 6'h01
    ) else $error("forward wrap past 63 wrong");

    a_wrap_down: assert property (
        commit_run && angle_r == ANGLE_RST && change == 6'h3e |=> angle_r == 6'h3e
    ) else $error("reverse wrap below 0 wrong");

    a_quarter_fwd: assert property (
        commit_run && change == 6'h04 |=> angle_r == $past(angle_r) + 6'h04
    ) else $error("quarter step forward not applied");

    a_zero_keep: assert property (
        commit_run && change == 6'h00 && !tbl_we |=> $stable(angle_r) ##1 $stable(dac_a_r)
            && $stable(dac_b_r)
    ) else $error("zero step change disturbed the motor");

    a_sck_no_move: assert property (
        sck_rise && !strobe_rise |=> $stable(angle_r) [*2]
    ) else $error("serial clock edge moved the angle");

    a_step_pulse: assert property (
        commit_run |=> STEP_PULSE ##1 (PHASE_A_NEG == angle_r[5])
    ) else $error("step pulse or phase sign missing after a step");

    a_default_code: assert property (
        !tbl_dirty_r && !tbl_we && angle_r == 6'h1c |=>
            dac_a_r == 6'h18 && dac_b_r == 6'h3b && dac_b_neg_r && !dac_a_neg_r
    ) else $error("default profile code wrong at angle 28");

    a_table_used: assert property (
        tbl_we && tbl_idx_r == TBL_LAST && angle_r == ANGLE_RST |=>
            ##1 (angle_r != ANGLE_RST || dac_b_r == $past(tbl_wdata, 2))
    ) else $error("loaded table entry not used");

    a_quadrant_sign: assert property (
        angle_r[5:4] == 2'b11 |=> !dac_b_neg_r && dac_a_neg_r
    ) else $error("fourth quadrant signs wrong");

    c_run_step: cover property (commit_run && change == 6'h04);
    c_run_back: cover property (commit_run && change == 6'h3c);
    c_table_load: cover property (tbl_we && tbl_idx_r == TBL_LAST);
    c_short_frame: cover property (state_r == SSAC_SHIFT && strobe_rise && cnt_r != WORD_CNT);

endmodule

`default_nettype wire

/* common/ssac_pkg.sv */
// constants, table defaults and the serial word layout of the step angle control
// assumes a 10 MHz core clock and a host that frames each word with the strobe
// What this block does
// - step angle number held within 0 to 63
// - angle changes wrap modulo 64
// - step change taken from word bits 0 to 5
// - step change is signed, added to angle
// - one unit equals one sixteenth microstep
// - angle moves only on strobe rising edge
// - step timing set by strobe, not serial clock
// - all motion controlled over serial interface
// - phase table reloadable, loaded profile is used
// - sinusoidal default profile works without loading
// - each phase current is a 6-bit code

package ssac_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // serial word
    localparam int WORD_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] WORD_CNT = 5'h10;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 14;
    localparam int CHANGE_HI = 5;
    localparam int CHANGE_LO = 0;
    localparam logic [1:0] REG_RUN = 2'h2;
    localparam logic [1:0] REG_TBL = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // angle and phase current
    localparam int ANGLE_W = 6;
    localparam logic [ANGLE_W-1:0] ANGLE_RST = 6'h00;
    localparam logic [ANGLE_W-1:0] ANGLE_MAX = 6'h3f;
    localparam int DAC_W = 6;
    localparam logic [DAC_W-1:0] DAC_ZERO = 6'h00;
    localparam int POS_W = 4;
    localparam int IDX_W = 5;
    localparam logic [IDX_W-1:0] QUAD_SPAN = 5'h10;
    localparam int TBL_DEPTH = 16;
    localparam logic [POS_W-1:0] TBL_FIRST = 4'h0;
    localparam logic [POS_W-1:0] TBL_LAST = 4'hf;
    localparam int SYNC_W = 3;

    // quarter sine in 64ths of full scale, entries 1..16; entry 0 is always zero
    localparam logic [DAC_W-1:0] DEF_TBL [TBL_DEPTH] = '{
        6'h06, 6'h0c, 6'h13, 6'h18, 6'h1e, 6'h24, 6'h29, 6'h2d,
        6'h31, 6'h35, 6'h38, 6'h3b, 6'h3d, 6'h3f, 6'h3f, 6'h3f
    };

    typedef enum logic [1:0] {
        SSAC_IDLE  = 2'b01,
        SSAC_SHIFT = 2'b10
    } ssac_ser_e;

endpackage

/* core/ssac_sync.sv */
// two-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous levels; pulses shorter than one clock may vanish
`timescale 1ns/1ps
`default_nettype none

module ssac_sync
    import ssac_pkg::*;
#(
    parameter int W = SYNC_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pins in, synchronised out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] stage1_r;
    logic [W-1:0] stage2_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            stage1_r <= '1;
            stage2_r <= '1;
        end else begin
            stage1_r <= din;
            stage2_r <= stage1_r;
        end
    end

    assign dout = stage2_r;

endmodule

`default_nettype wire

/* core/ssac_phase_table.sv */
// programmable quarter-wave phase current table, two read ports
// assumes the caller folds the angle into an index 0..16 per phase
`timescale 1ns/1ps
`default_nettype none

module ssac_phase_table
    import ssac_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // write port
    input wire logic we,
    input wire logic [POS_W-1:0] widx,
    input wire logic [DAC_W-1:0] wdata,
    // read ports
    input wire logic [IDX_W-1:0] idx_a,
    input wire logic [IDX_W-1:0] idx_b,
    output logic [DAC_W-1:0] mag_a,
    output logic [DAC_W-1:0] mag_b
);

    logic [DAC_W-1:0] mem_r [TBL_DEPTH];
    logic [DAC_W-1:0] mem_nxt [TBL_DEPTH];

    always_comb begin
        mem_nxt = mem_r;
        if (we) begin
            mem_nxt[widx] = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mem_r <= DEF_TBL;
        end else begin
            mem_r <= mem_nxt;
        end
    end

    // index 0 is the zero-current crossing and is not stored
    function automatic logic [DAC_W-1:0] rd(input logic [IDX_W-1:0] i);
        logic [IDX_W-1:0] j;
        j = i - 5'h01;
        rd = (i == '0) ? DAC_ZERO : mem_r[j[POS_W-1:0]];
    endfunction

    // a process, not an assign: a table write must reach the outputs at an unchanged index
    always_comb begin
        mag_a = rd(idx_a);
        mag_b = rd(idx_b);
    end

endmodule

`default_nettype wire

/* verif/ssac_host_model.sv */
// host side of the four-wire serial link: frames one word per request
// assumes CLOCK is the bench clock; link clock stands high between frames
`timescale 1ns/1ps
`default_nettype none

module ssac_host_model
    import ssac_pkg::*;
(
    // bench side
    input wire logic clk,
    input wire logic req,
    input wire logic [WORD_BITS-1:0] word,
    input wire logic [CNT_W-1:0] nbits,
    input wire logic [3:0] half_cyc,
    output logic done,
    output logic [WORD_BITS-1:0] rd_word,
    // serial pins
    output logic sck,
    output logic sdi,
    output logic strobe_n,
    input wire logic sdo
);
    initial begin
        done = 1'b0;
        rd_word = '0;
        sck = 1'b1;
        sdi = 1'b0;
        strobe_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one frame per request; link rate set by half_cyc alone
    always @(posedge clk) begin
        if (req && !done) begin
            strobe_n <= 1'b0;
            repeat (8) @(posedge clk);
            for (int i = 0; i < nbits; i++) begin
                // readback sampled before the fall that shifts it
                rd_word <= {rd_word[WORD_BITS-2:0], sdo};
                sck <= 1'b0;
                sdi <= word[WORD_BITS-1-i];
                repeat (half_cyc) @(posedge clk);
                sck <= 1'b1;
                repeat (half_cyc) @(posedge clk);
            end
            strobe_n <= 1'b1;
            // released data line: show the inverse, never a stale level
            sdi <= ~sdi;
            repeat (8) @(posedge clk);
            done <= 1'b1;
        end else begin
            done <= 1'b0;
        end
    end
endmodule

`default_nettype wire

/* verif/serial_step_angle_control_tb_top.sv */
// self-checking bench for the serial step angle control
// assumes the host model frames words; expectations come from bench functions
`timescale 1ns/1ps
`default_nettype none

module serial_step_angle_control_tb_top;
    import ssac_pkg::*;

    localparam logic [5:0] CORNER [15] = '{6'h3f, 6'h02, 6'h3e, 6'h3e, 6'h00, 6'h10,
        6'h08, 6'h04, 6'h02, 6'h30, 6'h38, 6'h3c, 6'h3e, 6'h20, 6'h1f};

    logic CLOCK, srst, sck, sdi, strobe_n, sdo, sdo_oe, step_pulse, a_neg, b_neg;
    logic req, done;
    logic [WORD_BITS-1:0] word, rd_word;
    logic [CNT_W-1:0] nbits;
    logic [3:0] half_cyc;
    logic [ANGLE_W-1:0] step_angle, prev_angle, ea;
    logic [DAC_W-1:0] a_dac, b_dac;
    logic [DAC_W-1:0] tbl [TBL_DEPTH];
    logic [POS_W-1:0] ptr;
    int bad_count, compares, pcnt;

    ssac_step_ctrl i_dut (.CLOCK(CLOCK), .SRST(srst), .SCK(sck), .SDI(sdi),
        .STROBE_ACTIVE_LOW(strobe_n), .SDO(sdo), .SDO_OE(sdo_oe), .STEP_ANGLE(step_angle),
        .STEP_PULSE(step_pulse), .PHASE_A_DAC(a_dac), .PHASE_A_NEG(a_neg),
        .PHASE_B_DAC(b_dac), .PHASE_B_NEG(b_neg));

    ssac_host_model i_host (.clk(CLOCK), .req(req), .word(word), .nbits(nbits),
        .half_cyc(half_cyc), .done(done), .rd_word(rd_word), .sck(sck), .sdi(sdi),
        .strobe_n(strobe_n), .sdo(sdo));

    always #50 CLOCK = ~CLOCK;

    ////////////////////////////////////////////////////////////////////////////
    // monitors
    always @(posedge CLOCK) begin
        if (step_pulse === 1'b1) begin
            pcnt <= pcnt + 1;
        end
        // angle must hold while a frame is open
        if (!srst && strobe_n === 1'b0 && step_angle !== prev_angle) begin
            bad_count++;
            $display("MISMATCH angle_in_frame expected %h seen %h", prev_angle, step_angle);
        end
        prev_angle <= step_angle;
        // link clock is only low inside a frame, so the readback driver must be on
        if (!srst && sck === 1'b0 && sdo_oe !== 1'b1) begin
            bad_count++;
            $display("MISMATCH sdo_oe expected 1 seen %b", sdo_oe);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic close_out();
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [DAC_W-1:0] mag(input logic [IDX_W-1:0] i);
        return (i == 5'h00) ? DAC_ZERO : tbl[i - 5'h01];
    endfunction

    task automatic check_state();
        logic [1:0] q;
        logic [IDX_W-1:0] p;
        q = ea[5:4];
        p = {1'b0, ea[3:0]};
        check("angle", {10'h0, ea}, {10'h0, step_angle});
        check("phase_a", {9'h0, q[1], mag(q[0] ? 5'h10 - p : p)}, {9'h0, a_neg, a_dac});
        check("phase_b", {9'h0, q[1] ^ q[0], mag(q[0] ? p : 5'h10 - p)},
            {9'h0, b_neg, b_dac});
    endtask

    task automatic send(input logic [15:0] w, input logic [CNT_W-1:0] nb, input logic [3:0] hc);
        int n;
        int p0;
        int step;
        n = 0;
        step = 0;
        p0 = pcnt;
        word <= w;
        nbits <= nb;
        half_cyc <= hc;
        req <= 1'b1;
        do begin
            @(posedge CLOCK);
            n++;
        end while (done !== 1'b1 && n < 5000);
        check("host_done", 16'h0001, {15'h0, done});
        req <= 1'b0;
        @(posedge CLOCK);
        check("sdo_oe_idle", 16'h0000, {15'h0, sdo_oe});
        if (nb == WORD_CNT) check("readback", {ea, ptr, 6'h00}, rd_word);
        if (nb == WORD_CNT && w[ADDR_HI:ADDR_LO] == REG_RUN) begin
            ea = ea + w[CHANGE_HI:CHANGE_LO];
            step = 1;
        end else if (nb == WORD_CNT && w[ADDR_HI:ADDR_LO] == REG_TBL) begin
            tbl[ptr] = w[CHANGE_HI:CHANGE_LO];
            ptr = ptr + 4'h1;
        end
        check("pulses", 16'(step), 16'(pcnt - p0));
        check_state();
    endtask

    task automatic restart();
        srst <= 1'b1;
        repeat (6) @(posedge CLOCK);
        srst <= 1'b0;
        ea = ANGLE_RST;
        ptr = TBL_FIRST;
        tbl = DEF_TBL;
        repeat (6) @(posedge CLOCK);
        check_state();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        CLOCK = 1'b0;
        srst = 1'b1;
        req = 1'b0;
        word = '0;
        nbits = WORD_CNT;
        half_cyc = 4'h4;
        pcnt = 0;
        prev_angle = '0;
        void'($urandom(32'hb8e3));
        restart();
        foreach (CORNER[i]) send({REG_RUN, 8'($urandom), CORNER[i]}, WORD_CNT, 4'h4);
        repeat (4) send({REG_RUN, 8'($urandom), 6'h04}, WORD_CNT, 4'h4);
        repeat (4) send({REG_RUN, 8'($urandom), 6'h3c}, WORD_CNT, 4'h5);
        send({REG_RUN, 8'h00, 6'h05}, 5'h0f, 4'h4);
        send({2'b00, 8'($urandom), 6'h05}, WORD_CNT, 4'h4);
        send({2'b01, 8'($urandom), 6'h07}, WORD_CNT, 4'h4);
        // back to angle 0 so the last table entry drives phase b as it is loaded
        send({REG_RUN, 8'($urandom), 6'(6'h00 - ea)}, WORD_CNT, 4'h4);
        repeat (16) send({REG_TBL, 8'($urandom), 6'($urandom)}, WORD_CNT, 4'h4);
        repeat (40) send({REG_RUN, 14'($urandom)}, WORD_CNT, 4'(4 + $urandom % 4));
        restart();
        // 0 minus 2 wraps to 62, then on to 28 on the default profile
        send({REG_RUN, 8'($urandom), 6'h3e}, WORD_CNT, 4'h4);
        send({REG_RUN, 8'($urandom), 6'h1e}, WORD_CNT, 4'h4);
        repeat (8) send({REG_RUN, 14'($urandom)}, WORD_CNT, 4'h6);
        close_out();
    end

    initial begin
        #5_000_000;
        bad_count++;
        close_out();
    end
endmodule

`default_nettype wire
